// ===== design/mft_timing.sv
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module mft_timing (
   input wire logic clk,
   input wire logic reset,
   input wire mft_pkg::mft_wb_req_s wbReq,
   output logic [31:0] wbDatO,
   output logic wbAckO,
   input wire logic extClkA,
   input wire logic extClkB,
   input wire logic [mft_pkg::NUM_REG-1:0] timerIoPinIn,
   output logic [mft_pkg::NUM_REG-1:0] timerIoPinOut,
   output logic [mft_pkg::NUM_REG-1:0] timerIoPinOe,
   output logic [mft_pkg::NUM_REG-1:0] matchCaptureIrq,
   output logic overflowIrq,
   output logic underflowIrq,
   output logic irq
);
   mft_pkg::mft_state_s q;
   mft_pkg::mft_state_s d;
   logic access;
   logic wr;
   logic rd;
   logic open;
   logic wrCount;
   logic intTick;
   logic extTick;
   logic tick;
   logic up;
   logic down;
   logic clear;
   logic ovf;
   logic unf;
   logic [1:0] aE;
   logic [1:0] bE;
   logic [3:0] setFlags;
   logic [3:0] clrFlags;
   logic [mft_pkg::NUM_REG-1:0] match;
   logic [mft_pkg::NUM_REG-1:0] cap;
   logic [mft_pkg::NUM_REG-1:0] mcrHit;
   logic [mft_pkg::NUM_REG-1:0] regLive;
   logic [31:0] ctrlMerged;
   logic [31:0] pinMerged;
   logic [31:0] countMerged;
   logic [mft_pkg::NUM_REG-1:0][31:0] mcrMerged;

   // Byte-lane merge so sel is honoured on every writable register
   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] dat,
                                              input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (dat & m);
   endfunction : mergeBytes

   // Write data merged per register, cut to each register's width where used
   assign ctrlMerged = mergeBytes({23'h0, q.ctrl}, wbReq.dat, wbReq.sel);
   assign pinMerged = mergeBytes({24'h0, q.pinSet}, wbReq.dat, wbReq.sel);
   assign countMerged = mergeBytes({16'h0, q.count}, wbReq.dat, wbReq.sel);

   // Bus decode; a request is taken once, in the cycle before ack
   assign access = wbReq.cyc & wbReq.stb & ~q.ack;
   assign wr = access & wbReq.we;
   assign rd = access & ~wbReq.we;
   assign open = ~q.standby;
   assign wrCount = wr & open & (wbReq.adr == mft_pkg::OFS_COUNT);

   // Edges of the synchronised external clocks: rise in bit 0, fall in bit 1
   assign aE = {q.extPrev[0] & ~q.extSync2[0], ~q.extPrev[0] & q.extSync2[0]};
   assign bE = {q.extPrev[1] & ~q.extSync2[1], ~q.extPrev[1] & q.extSync2[1]};

   // Internal prescaler taps; division 1, 4, 16 or 64
   always_comb
   begin
      case (q.ctrl.psc)
         2'h0: intTick = 1'b1;
         2'h1: intTick = (q.psc[1:0] == 2'h0);
         2'h2: intTick = (q.psc[3:0] == 4'h0);
         default: intTick = (q.psc == 6'h00);
      endcase
   end

   // Pulse widths below the limits can lose edges in the synchroniser
   always_comb
   begin
      if (q.ctrl.phase)
         extTick = |{aE, bE};
      else if (q.ctrl.edgeSel == mft_pkg::EDGE_BOTH)
         extTick = |aE;
      else if (q.ctrl.edgeSel == mft_pkg::EDGE_FALL)
         extTick = aE[1];
      else
         extTick = aE[0];
   end

   // Count input clock; standby halts the unit
   assign tick = open & ((q.ctrl.ext | q.ctrl.phase) ? extTick : intTick);
   // Phase counting direction from which input leads
   assign up = (aE[0] & ~q.extSync2[1]) | (aE[1] & q.extSync2[1])
             | (bE[0] & q.extSync2[0]) | (bE[1] & ~q.extSync2[0]);
   assign down = q.ctrl.phase & ~up;

   // Per-register match and capture; register 1 is a buffer in buffer mode
   genvar g;
   generate
      for (g = 0; g < mft_pkg::NUM_REG; g++)
      begin : gReg
         assign mcrHit[g] = wbReq.adr == 8'(mft_pkg::OFS_MCR0 + mft_pkg::MCR_STRIDE * g);
         assign regLive[g] = ~(q.ctrl.bufEn && g == 1);
         assign mcrMerged[g] = mergeBytes({16'h0, q.mcr[g]}, wbReq.dat, wbReq.sel);
         // Only on the cycle the count updates, so one match per input clock
         assign match[g] = tick & regLive[g] & ~q.pinSet[g].capMode & (q.count == q.mcr[g]);
         assign cap[g] = open & regLive[g] & q.pinSet[g].capMode
                       & (q.pinSet[g].capFall ? (q.capPrev[g] & ~q.capSync2[g])
                                              : (~q.capPrev[g] & q.capSync2[g]));
      end
   endgenerate

   // Clear on match or capture of the chosen register
   assign clear = (q.ctrl.clrSel == mft_pkg::CLR_REG0 && (match[0] || cap[0]))
                | (q.ctrl.clrSel == mft_pkg::CLR_REG1 && (match[1] || cap[1]));
   assign ovf = tick & ~down & (q.count == mft_pkg::COUNT_MAX) & ~clear;
   assign unf = tick & down & (q.count == mft_pkg::COUNT_ZERO) & ~clear;
   assign setFlags = {unf, ovf, match | cap};

   // Next state of the whole block
   always_comb
   begin
      d = q;
      clrFlags = 4'h0;
      d.extSync1 = {extClkB, extClkA};
      d.extSync2 = q.extSync1;
      d.extPrev = q.extSync2;
      d.capSync1 = timerIoPinIn;
      d.capSync2 = q.capSync1;
      d.capPrev = q.capSync2;
      d.psc = q.psc + 6'h01;
      d.ack = access;
      d.rdata = 32'h0000_0000;
      // Register writes; in standby only the standby bit takes a write
      if (wr)
      begin
         if (wbReq.adr == mft_pkg::OFS_STANDBY && wbReq.sel[0])
            d.standby = wbReq.dat[0];
         else if (open && wbReq.adr == mft_pkg::OFS_CTRL)
            d.ctrl = mft_pkg::mft_ctrl_s'(ctrlMerged[8:0]);
         else if (open && wbReq.adr == mft_pkg::OFS_PINSET)
            d.pinSet = mft_pkg::mft_pinset_t'(pinMerged[7:0]);
         else if (open && wbReq.adr == mft_pkg::OFS_INTEN && wbReq.sel[0])
            d.inten = wbReq.dat[3:0];
         else if (open && wbReq.adr == mft_pkg::OFS_MASK && wbReq.sel[0])
            d.mask = wbReq.dat[3:0];
         else if (open && wbReq.adr == mft_pkg::OFS_STATUS && wbReq.sel[0])
         begin
            clrFlags = q.armed & ~wbReq.dat[3:0];
            d.armed = 4'h0;
         end
      end
      // Capture beats a software write to the same register
      for (int i = 0; i < mft_pkg::NUM_REG; i++)
      begin
         if (wr && open && mcrHit[i] && !cap[i])
            d.mcr[i] = mcrMerged[i][15:0];
         if (cap[i])
            d.mcr[i] = q.count;
         if (match[i])
         begin
            case (q.pinSet[i].action)
               mft_pkg::ACT_LOW: d.pinOut[i] = 1'b0;
               mft_pkg::ACT_HIGH: d.pinOut[i] = 1'b1;
               mft_pkg::ACT_TOGGLE: d.pinOut[i] = ~q.pinOut[i];
               default: d.pinOut[i] = q.pinOut[i];
            endcase
         end
         d.pinOe[i] = open & ~d.pinSet[i].capMode & (d.pinSet[i].action != mft_pkg::ACT_NONE);
      end
      // Buffer transfers use the old buffer value, so a same-cycle write is lost
      if (q.ctrl.bufEn)
      begin
         if (cap[0])
            d.mcr[1] = q.mcr[0];
         else if (match[0] || clear)
            d.mcr[0] = q.mcr[1];
      end
      // Counter: clear, then write, then count
      if (clear)
         d.count = mft_pkg::COUNT_ZERO;
      else if (wrCount)
         d.count = countMerged[15:0];
      else if (tick)
         d.count = down ? q.count - mft_pkg::COUNT_STEP : q.count + mft_pkg::COUNT_STEP;
      if (tick && q.ctrl.phase)
         d.dirDown = down;
      // Reading status arms the clear of the flags seen as 1
      if (rd && open && wbReq.adr == mft_pkg::OFS_STATUS)
         d.armed = q.flags;
      // Setting wins over clearing
      d.flags = (q.flags & ~clrFlags) | setFlags;
      d.evt = ((rd && open && wbReq.adr == mft_pkg::OFS_EVENT) ? 4'h0 : q.evt) | setFlags;
      // Read mux; unmapped or standby-blocked words read as zero
      if (rd)
      begin
         if (wbReq.adr == mft_pkg::OFS_STANDBY)
            d.rdata = {31'h0, q.standby};
         else if (open && wbReq.adr == mft_pkg::OFS_CTRL)
            d.rdata = {23'h0, q.ctrl};
         else if (open && wbReq.adr == mft_pkg::OFS_PINSET)
            d.rdata = {24'h0, q.pinSet};
         else if (open && wbReq.adr == mft_pkg::OFS_INTEN)
            d.rdata = {28'h0, q.inten};
         else if (open && wbReq.adr == mft_pkg::OFS_STATUS)
            d.rdata = {27'h0, q.dirDown, q.flags};
         else if (open && wbReq.adr == mft_pkg::OFS_COUNT)
            d.rdata = {16'h0, q.count};
         else if (open && mcrHit[0])
            d.rdata = {16'h0, q.mcr[0]};
         else if (open && mcrHit[1])
            d.rdata = {16'h0, q.mcr[1]};
         else if (open && wbReq.adr == mft_pkg::OFS_EVENT)
            d.rdata = {28'h0, q.evt};
         else if (open && wbReq.adr == mft_pkg::OFS_MASK)
            d.rdata = {28'h0, q.mask};
      end
      // Requests follow flag and enable levels; irq follows event and mask levels
      d.irqLines = d.flags & d.inten;
      d.irq = |(d.evt & d.mask);
   end

   // The only state register; reset parks the unit in standby
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         q <= '0;
         q.standby <= mft_pkg::STANDBY_RST;
      end
      else
         q <= d;
   end

   // Outputs straight from the state register
   assign wbDatO = q.rdata;
   assign wbAckO = q.ack;
   assign timerIoPinOut = q.pinOut;
   assign timerIoPinOe = q.pinOe;
   assign matchCaptureIrq = q.irqLines[mft_pkg::NUM_REG-1:0];
   assign overflowIrq = q.irqLines[mft_pkg::FLAG_OVF];
   assign underflowIrq = q.irqLines[mft_pkg::FLAG_UNF];
   assign irq = q.irq;

   // Checks on the timing core
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // Wrap events as sequences, shared by the flag checks
   sequence ovfSeq;
      tick && !down && q.count == 16'hffff && !clear;
   endsequence
   sequence unfSeq;
      tick && down && q.count == 16'h0000 && !clear;
   endsequence

   // Match, pin and single-match checks
   match_on_update_a: assert property (match[0] |-> tick && q.count == q.mcr[0])
      else $error("match without equal count or update");
   pin_level_a: assert property (match[0] && q.pinSet[0].action == mft_pkg::ACT_HIGH
      |=> timerIoPinOut[0]) else $error("pin not driven high on match");
   single_match_a: assert property (!tick |-> match == '0)
      else $error("match without count input clock");

   // Flag clearing, standby and counter clearing
   flag_clear_a: assert property ($fell(q.flags[0]) |-> $past(q.armed[0]))
      else $error("flag cleared without prior read");
   standby_hold_a: assert property (q.standby |=> $stable(q.count) && $stable(q.ctrl))
      else $error("counter or control moved in standby");
   clear_match_a: assert property (match[0] && q.ctrl.clrSel == mft_pkg::CLR_REG0
      |=> q.count == 16'h0000) else $error("counter not cleared on match");
   clear_wins_a: assert property (clear && wrCount |=> q.count == 16'h0000)
      else $error("counter write beat clear");

   // Flags and requests raised by events
   overflow_a: assert property (ovfSeq ##1 q.inten[2] |-> q.flags[2] && overflowIrq)
      else $error("overflow flag or request missing");
   underflow_a: assert property (unfSeq ##1 q.inten[3] |-> q.flags[3] && underflowIrq)
      else $error("underflow flag or request missing");
   match_flag_a: assert property (match[0] |=> q.flags[0])
      else $error("match flag not set");
   capture_copy_a: assert property (cap[1] |=> q.flags[1] && q.mcr[1] == $past(q.count))
      else $error("capture did not store count");
   buffer_load_a: assert property (match[0] && q.ctrl.bufEn && !cap[0]
      |=> q.mcr[0] == $past(q.mcr[1])) else $error("buffer not moved on match");
   irq_drop_a: assert property ($fell(q.flags[0]) |-> !matchCaptureIrq[0])
      else $error("request stands after flag clear");

   // Bus, standby and request-level checks
   ack_pulse_a: assert property (wbAckO |=> !wbAckO)
      else $error("ack stood for two cycles");
   standby_read_a: assert property (q.standby && rd && wbReq.adr != mft_pkg::OFS_STANDBY
      |=> wbDatO == 32'h0000_0000) else $error("register readable in standby");
   irq_level_a: assert property (q.flags[0] && q.inten[0] |-> matchCaptureIrq[0])
      else $error("request missing while flag and enable set");
   capture_oe_a: assert property (q.pinSet[1].capMode |-> !timerIoPinOe[1])
      else $error("capture pin driven");
   unf_wrap_a: assert property (unfSeq ##0 !wrCount |=> q.count == 16'hffff)
      else $error("count did not wrap on underflow");
endmodule : mft_timing

// ===== design/mft_pkg.sv
// How it works
// - A compare match pulses in the last cycle the count equals a register, when the count updates.
// - A compare match drives the timer I/O pin to the level chosen in that pin's action setting.
// - After a match no further match is signalled until the next count input clock pulse.
// - A status flag clears only on a 0-write that follows a read of it as 1; other 0-writes do nothing.
// - After reset the unit sits in standby, halted, and only the standby bit is reachable.
// - Clearing on match clears the counter in the final matching cycle, a period of N+1 clocks.
// - A counter clear in the same cycle as a software counter write wins and the write is lost.
// - A wrap from ffff to 0000 sets the overflow flag and its request when enabled.
// - An underflow while counting down sets the underflow flag and its request when enabled.
// - A compare match sets its match/capture flag and its request when enabled.
// - An input capture sets its match/capture flag and its request when enabled.
// - A match/capture request stands while flag and enable are set and drops when the flag clears.
package mft_pkg;
   localparam int NUM_REG = 2;
   localparam int CNT_W = 16;
   // Byte offsets on the register bus
   localparam logic [7:0] OFS_STANDBY = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_PINSET = 8'h08;
   localparam logic [7:0] OFS_INTEN = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_COUNT = 8'h14;
   localparam logic [7:0] OFS_MCR0 = 8'h18;
   localparam logic [7:0] MCR_STRIDE = 8'h04;
   localparam logic [7:0] OFS_EVENT = 8'h20;
   localparam logic [7:0] OFS_MASK = 8'h24;
   // Flag positions in status, enable, event and mask
   localparam int FLAG_OVF = 2;
   localparam int FLAG_UNF = 3;
   localparam int FLAG_DIR = 4;
   // Reset values and counter limits
   localparam logic STANDBY_RST = 1'b1;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_STEP = 16'h0001;

   typedef enum logic [1:0] {EDGE_RISE = 2'h0, EDGE_FALL = 2'h1, EDGE_BOTH = 2'h3} mft_edge_e;
   typedef enum logic [1:0] {ACT_NONE = 2'h0, ACT_LOW = 2'h1, ACT_HIGH = 2'h2,
                             ACT_TOGGLE = 2'h3} mft_act_e;
   typedef enum logic [1:0] {CLR_NONE = 2'h0, CLR_REG0 = 2'h1, CLR_REG1 = 2'h3} mft_clr_e;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } mft_wb_req_s;

   typedef struct packed {
      logic bufEn;
      mft_clr_e clrSel;
      logic phase;
      mft_edge_e edgeSel;
      logic ext;
      logic [1:0] psc;
   } mft_ctrl_s;

   typedef struct packed {
      logic capFall;
      logic capMode;
      mft_act_e action;
   } mft_pin_s;

   typedef mft_pin_s [NUM_REG-1:0] mft_pinset_t;

   typedef struct packed {
      logic standby;
      mft_ctrl_s ctrl;
      mft_pinset_t pinSet;
      logic [3:0] inten;
      logic [3:0] flags;
      logic [3:0] armed;
      logic [3:0] evt;
      logic [3:0] mask;
      logic [CNT_W-1:0] count;
      logic [NUM_REG-1:0][CNT_W-1:0] mcr;
      logic [NUM_REG-1:0] pinOut;
      logic [NUM_REG-1:0] pinOe;
      logic [3:0] irqLines;
      logic irq;
      logic dirDown;
      logic [5:0] psc;
      logic [1:0] extSync1;
      logic [1:0] extSync2;
      logic [1:0] extPrev;
      logic [NUM_REG-1:0] capSync1;
      logic [NUM_REG-1:0] capSync2;
      logic [NUM_REG-1:0] capPrev;
      logic ack;
      logic [31:0] rdata;
   } mft_state_s;
endpackage : mft_pkg

// ===== bench/mft_pins_model.sv
`timescale 1ns/1ps
// Far-side pins: phase clocks and capture inputs
module mft_pins_model (
   input wire logic clk,
   output logic extClkA,
   output logic extClkB,
   output logic [1:0] capPin
);
   // Idle low between bursts; nothing runs free
   initial
   begin
      extClkA = 1'b0;
      extClkB = 1'b0;
      capPin = 2'h0;
   end

   // Four clocks per step keeps width 4 and phase gap 4
   task automatic step(input logic a, input logic b);
      @(posedge clk);
      extClkA <= a;
      extClkB <= b;
      repeat (3) @(posedge clk);
   endtask : step

   // B leads A, so the count runs down
   task automatic phase_down(input int n);
      repeat (n)
      begin
         step(1'b0, 1'b1);
         step(1'b1, 1'b1);
         step(1'b1, 1'b0);
         step(1'b0, 1'b0);
      end
   endtask : phase_down

   // Pulses on A alone, width and gap of four clocks
   task automatic pulse_a(input int n);
      repeat (n)
      begin
         step(1'b1, 1'b0);
         step(1'b0, 1'b0);
      end
   endtask : pulse_a

   // Rising then falling capture edge, each held well past sync
   task automatic cap_pulse(input int i);
      @(posedge clk);
      capPin[i] <= 1'b1;
      repeat (6) @(posedge clk);
      capPin[i] <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : cap_pulse
endmodule : mft_pins_model

// ===== bench/mft_timing_tb.sv
`timescale 1ns/1ps
module mft_timing_tb;
   logic clk;
   logic reset;
   mft_pkg::mft_wb_req_s wbReq;
   logic [31:0] wbDatO;
   logic wbAckO;
   logic extClkA;
   logic extClkB;
   logic [1:0] capPin;
   logic [1:0] pinOut;
   logic [1:0] pinOe;
   logic [1:0] mcIrq;
   logic ovfIrq;
   logic unfIrq;
   logic irq;
   int errors;
   int n_tests;
   logic [31:0] seed;
   logic [31:0] expQ[$];
   logic [31:0] mskQ[$];

   mft_timing u_mft_timing (.clk(clk), .reset(reset), .wbReq(wbReq), .wbDatO(wbDatO),
      .wbAckO(wbAckO), .extClkA(extClkA), .extClkB(extClkB), .timerIoPinIn(capPin),
      .timerIoPinOut(pinOut), .timerIoPinOe(pinOe), .matchCaptureIrq(mcIrq),
      .overflowIrq(ovfIrq), .underflowIrq(unfIrq), .irq(irq));
   mft_pins_model u_mft_pins_model (.clk(clk), .extClkA(extClkA), .extClkB(extClkB),
      .capPin(capPin));

   // Clock at 5 ns
   always #2.5 clk = ~clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   task automatic stop_test();
      if (errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   // One classic cycle; only the watchdog ends a wait on a dead slave
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
      @(posedge clk);
      while (wbAckO !== 1'b1)
         @(posedge clk);
      wbReq <= '0;
      @(posedge clk);
   endtask : bus

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      bus(1'b1, adr, dat);
   endtask : wr

   task automatic rd(input logic [7:0] adr, input logic [31:0] e, input logic [31:0] m);
      expQ.push_back(e);
      mskQ.push_back(m);
      bus(1'b0, adr, 32'h0);
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic chk(input logic got, input logic e);
      n_tests++;
      if (got !== e)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask : chk

   // Scoreboard: each read ack takes the oldest note
   always @(posedge clk)
   begin
      if (wbAckO === 1'b1 && wbReq.we === 1'b0)
      begin
         n_tests++;
         if (expQ.size() == 0)
         begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, wbDatO, 32'h0);
         end
         else if ((wbDatO & mskQ[0]) !== (expQ[0] & mskQ[0]))
         begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, wbDatO, expQ[0]);
         end
         if (expQ.size() != 0)
         begin
            void'(expQ.pop_front());
            void'(mskQ.pop_front());
         end
      end
   end

   // Watchdog, far above the few hundred cycles the sequence needs
   initial
   begin
      #250000;
      errors++;
      stop_test();
   end

   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      wbReq = '0;
      errors = 0;
      n_tests = 0;
      seed = 32'h56;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(mft_pkg::OFS_STANDBY, 32'h1, 32'hffffffff);
      wr(mft_pkg::OFS_COUNT, 32'h1234);
      rd(mft_pkg::OFS_COUNT, 32'h0, 32'hffffffff);
      wr(mft_pkg::OFS_STANDBY, 32'h0);
      // Compare value kept high so it never matches the short period below
      seed = xs(seed);
      wr(mft_pkg::OFS_MCR0 + mft_pkg::MCR_STRIDE, {16'h0, seed[15:0] | 16'h8000});
      rd(mft_pkg::OFS_MCR0 + mft_pkg::MCR_STRIDE, {16'h0, seed[15:0] | 16'h8000}, 32'hffffffff);
      wr(mft_pkg::OFS_MCR0, 32'h7);
      wr(mft_pkg::OFS_PINSET, 32'h2);
      wr(mft_pkg::OFS_INTEN, 32'h7);
      wr(mft_pkg::OFS_CTRL, 32'h40);
      wr(mft_pkg::OFS_COUNT, 32'h0);
      settle(20);
      chk(pinOut[0], 1'b1);
      chk(pinOe[0], 1'b1);
      chk(mcIrq[0], 1'b1);
      // N = 7 must hold the count in 0..7
      rd(mft_pkg::OFS_COUNT, 32'h0, 32'hfffffff8);
      // Slow ticks so no new match lands inside the clearing steps
      wr(mft_pkg::OFS_CTRL, 32'h43);
      wr(mft_pkg::OFS_COUNT, 32'h0);
      wr(mft_pkg::OFS_STATUS, 32'h0);
      settle(2);
      chk(mcIrq[0], 1'b1);
      rd(mft_pkg::OFS_STATUS, 32'h1, 32'h1);
      wr(mft_pkg::OFS_STATUS, 32'h0);
      settle(2);
      chk(mcIrq[0], 1'b0);
      // Capture on register 1 overwrites the high random value
      wr(mft_pkg::OFS_CTRL, 32'h40);
      wr(mft_pkg::OFS_PINSET, 32'h42);
      u_mft_pins_model.cap_pulse(1);
      settle(1);
      chk(mcIrq[1], 1'b1);
      chk(pinOe[1], 1'b0);
      rd(mft_pkg::OFS_MCR0 + mft_pkg::MCR_STRIDE, 32'h0, 32'hfffffff8);
      // Free run across the wrap
      wr(mft_pkg::OFS_CTRL, 32'h0);
      wr(mft_pkg::OFS_COUNT, 32'hfff0);
      settle(30);
      chk(ovfIrq, 1'b1);
      rd(mft_pkg::OFS_STATUS, 32'h4, 32'h4);
      // Event register, mask and read-clear
      wr(mft_pkg::OFS_MASK, 32'h4);
      settle(2);
      chk(irq, 1'b1);
      wr(mft_pkg::OFS_MASK, 32'h0);
      settle(2);
      chk(irq, 1'b0);
      wr(mft_pkg::OFS_MASK, 32'h4);
      rd(mft_pkg::OFS_EVENT, 32'h4, 32'h4);
      settle(2);
      chk(irq, 1'b0);
      // Phase counting down through zero
      wr(mft_pkg::OFS_INTEN, 32'hb);
      wr(mft_pkg::OFS_CTRL, 32'h24);
      wr(mft_pkg::OFS_COUNT, 32'h1);
      u_mft_pins_model.phase_down(3);
      settle(6);
      chk(unfIrq, 1'b1);
      rd(mft_pkg::OFS_STATUS, 32'h18, 32'h18);
      // External clock on A: rising edges only, then both edges
      wr(mft_pkg::OFS_CTRL, 32'h04);
      wr(mft_pkg::OFS_COUNT, 32'h0);
      u_mft_pins_model.pulse_a(2);
      rd(mft_pkg::OFS_COUNT, 32'h2, 32'hffffffff);
      wr(mft_pkg::OFS_CTRL, 32'h1c);
      wr(mft_pkg::OFS_COUNT, 32'h0);
      u_mft_pins_model.pulse_a(2);
      rd(mft_pkg::OFS_COUNT, 32'h4, 32'hffffffff);
      // Buffer mode: register 1 reloads register 0 at each match and clear
      wr(mft_pkg::OFS_MCR0 + mft_pkg::MCR_STRIDE, 32'h5);
      wr(mft_pkg::OFS_CTRL, 32'h140);
      settle(12);
      rd(mft_pkg::OFS_MCR0, 32'h5, 32'hffffffff);
      stop_test();
   end
endmodule : mft_timing_tb
